/* File: core/bsc_pkg.sv */
// Package for the barrel shifter and carry unit
// Assumes a single-clock core; shared by the shifter and its users
package bsc_pkg;

  localparam int unsigned BSC_W       = 32;
  localparam int unsigned BSC_AMT_W   = 8;
  localparam int unsigned BSC_MSB     = 31;
  localparam int unsigned BSC_LSB     = 0;
  localparam int unsigned BSC_FULL    = 32;
  localparam int unsigned BSC_BEYOND  = 33;
  localparam logic [31:0] BSC_RST_RES = 32'h0000_0000;
  localparam logic        BSC_RST_C   = 1'b0;

  // Shift kinds
  typedef enum logic [2:0] {
    BSC_ARITH_SHIFT_RIGHT,
    BSC_LOGIC_SHIFT_RIGHT,
    BSC_LOGIC_SHIFT_LEFT,
    BSC_ROTATE_RIGHT,
    BSC_ROTATE_THROUGH_CARRY
  } bsc_kind_t;

  // Requester of the shift
  typedef enum logic {
    BSC_REQ_STANDALONE,
    BSC_REQ_OPERAND2
  } bsc_req_t;

  typedef struct packed {
    logic                 valid;
    bsc_req_t             req;
    bsc_kind_t            kind;
    logic [BSC_AMT_W-1:0] amount;
    logic [BSC_W-1:0]     data;
    logic                 carry_in;
    logic                 flag_upd;
  } bsc_op_t;

  typedef struct packed {
    logic             valid;
    bsc_req_t         req;
    logic [BSC_W-1:0] result;
    logic             carry_out;
    logic             carry_wr;
  } bsc_res_t;

endpackage

/* File: core/bsc_shifter.sv */
// Barrel shifter with carry-out for the execute stage
// Assumes decode drives OP in step with CLK; result is registered
// Function
// - Serve standalone shifts and operand2 preprocessing
// - Zero amount passes input unchanged, except rotate through carry
// - Carry updates on request; zero amount keeps it, except rotate through carry
// - Arith right shifts, replicates sign bit
// - Arith right carry is last bit out
// - Arith right 32 plus gives sign
// - Logic right shifts, fills zeros on top
// - Logic right carry is last bit out
// - Logic shifts of 32 plus give zero
// - Logic shifts 33 plus clear carry
// - Logic left shifts, fills zeros below
// - Left carry takes bit 32-n; zero keeps
// - Rotate right wraps low bits to top
// - Rotate right carry takes bit n-1
// - Rotate by 32 returns input, carry bit 31
// - Rotate above 32 acts as n-32
// - Rotate through carry inserts carry at top
// - Rotate through carry new carry bit 0
`timescale 1ns/1ps

module bsc_shifter
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Request from decode
  input  wire bsc_pkg::bsc_op_t  OP,
  // Registered answer
  output bsc_pkg::bsc_res_t      RES
);

  import bsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Combinational shift

  bsc_res_t res_r;
  bsc_res_t res_nxt;
  logic [BSC_W-1:0]     d;
  logic [BSC_AMT_W-1:0] n;
  logic [BSC_AMT_W-1:0] rn;
  logic [4:0]           n5;
  logic [4:0]           rn5;
  logic [63:0]          dbl;
  logic                 cout;
  logic [BSC_W-1:0]     y;

  always_comb begin
    d    = OP.data;
    n    = OP.amount;
    n5   = n[4:0];
    // Rotate reduced modulo 32, 32 itself kept distinct
    rn   = (n > BSC_AMT_W'(BSC_FULL)) ? n - BSC_AMT_W'(BSC_FULL) : n;
    rn5  = rn[4:0];
    dbl  = {d, d};
    y    = d;
    cout = OP.carry_in;
    if (n == '0 && OP.kind != BSC_ROTATE_THROUGH_CARRY) begin
      y    = d;
      cout = OP.carry_in;
    end else begin
      unique case (OP.kind)
        BSC_ARITH_SHIFT_RIGHT: begin
          if (n >= BSC_AMT_W'(BSC_FULL)) begin
            y    = {BSC_W{d[BSC_MSB]}};
            cout = d[BSC_MSB];
          end else begin
            y    = BSC_W'($signed(d) >>> n5);
            cout = d[n5 - 5'd1];
          end
        end
        BSC_LOGIC_SHIFT_RIGHT: begin
          if (n >= BSC_AMT_W'(BSC_BEYOND)) begin
            y    = '0;
            cout = 1'b0;
          end else if (n == BSC_AMT_W'(BSC_FULL)) begin
            y    = '0;
            cout = d[BSC_MSB];
          end else begin
            y    = d >> n5;
            cout = d[n5 - 5'd1];
          end
        end
        BSC_LOGIC_SHIFT_LEFT: begin
          if (n >= BSC_AMT_W'(BSC_BEYOND)) begin
            y    = '0;
            cout = 1'b0;
          end else if (n == BSC_AMT_W'(BSC_FULL)) begin
            y    = '0;
            cout = d[BSC_LSB];
          end else begin
            y    = d << n5;
            cout = d[5'(BSC_FULL) - n5];
          end
        end
        BSC_ROTATE_RIGHT: begin
          if (rn == BSC_AMT_W'(BSC_FULL) || rn5 == 5'd0) begin
            y    = d;
            cout = d[BSC_MSB];
          end else begin
            y    = dbl[rn5 +: BSC_W];
            cout = d[rn5 - 5'd1];
          end
        end
        BSC_ROTATE_THROUGH_CARRY: begin
          y    = {OP.carry_in, d[BSC_W-1:1]};
          cout = d[BSC_LSB];
        end
        default: begin
          y    = d;
          cout = OP.carry_in;
        end
      endcase
    end
    res_nxt.valid     = OP.valid;
    res_nxt.req       = OP.req;
    res_nxt.result    = y;
    res_nxt.carry_wr  = OP.valid && OP.flag_upd &&
                        (n != '0 || OP.kind == BSC_ROTATE_THROUGH_CARRY);
    res_nxt.carry_out = res_nxt.carry_wr ? cout : OP.carry_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output register

  always_ff @(posedge CLK) begin
    if (SRST) begin
      res_r.valid     <= 1'b0;
      res_r.req       <= BSC_REQ_STANDALONE;
      res_r.result    <= BSC_RST_RES;
      res_r.carry_out <= BSC_RST_C;
      res_r.carry_wr  <= 1'b0;
    end else begin
      res_r <= res_nxt;
    end
  end

  assign RES = res_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_ZERO_PASS: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.amount == '0 && OP.kind != BSC_ROTATE_THROUGH_CARRY
    |=> RES.result == $past(OP.data) && !RES.carry_wr)
    else $error("zero shift altered data or carry");

  AST_CARRY_KEEP: assert property (@(posedge CLK) disable iff (SRST)
    !RES.carry_wr |-> RES.carry_out == $past(OP.carry_in))
    else $error("carry changed without update");

  AST_ARITH_BIG: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_ARITH_SHIFT_RIGHT && OP.amount >= 8'd32
    |=> RES.result == {32{$past(OP.data[31])}})
    else $error("arith shift 32 plus not sign fill");

  AST_ARITH_CARRY: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ARITH_SHIFT_RIGHT
    && OP.amount == 8'd1 |=> RES.carry_out == $past(OP.data[0]))
    else $error("arith shift carry not last bit out");

  AST_LOGIC_ZERO: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.amount >= 8'd32 && (OP.kind == BSC_LOGIC_SHIFT_RIGHT
    || OP.kind == BSC_LOGIC_SHIFT_LEFT) |=> RES.result == 32'h0000_0000)
    else $error("logic shift 32 plus not zero");

  AST_LOGIC_CLR: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.amount >= 8'd33
    && OP.kind == BSC_LOGIC_SHIFT_LEFT |=> RES.carry_wr && !RES.carry_out)
    else $error("logic shift 33 plus carry not cleared");

  AST_LEFT_CARRY: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_LOGIC_SHIFT_LEFT
    && OP.amount == 8'd1 |=> RES.carry_out == $past(OP.data[31]))
    else $error("left shift carry not bit 32-n");

  AST_ROT_FULL: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_ROTATE_RIGHT && OP.amount == 8'd32
    |=> RES.result == $past(OP.data))
    else $error("rotate by 32 not identity");

  AST_THRU_RESULT: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_ROTATE_THROUGH_CARRY
    |=> RES.result == {$past(OP.carry_in), $past(OP.data[31:1])})
    else $error("rotate through carry result wrong");

  AST_THRU_CARRY: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ROTATE_THROUGH_CARRY
    |=> RES.carry_out == $past(OP.data[0]))
    else $error("rotate through carry not bit 0");

  ////////////////////////////////////////////////////////////////////////
  // Per-kind datapath checks, plus echo, idle, carry-write and reset checks

  AST_VALID_ECHO: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid
    |=> RES.valid
    && RES.req == $past(OP.req))
    else $error("valid or requester not echoed");

  AST_IDLE_QUIET: assert property (@(posedge CLK) disable iff (SRST)
    !OP.valid
    |=> !RES.valid
    && !RES.carry_wr)
    else $error("idle cycle produced an answer");

  AST_ARITH_MID: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_ARITH_SHIFT_RIGHT
    && OP.amount == 8'h04
    |=> RES.result == {{4{$past(OP.data[31])}}, $past(OP.data[31:4])})
    else $error("arith shift by four wrong");

  AST_ARITH_SIGN_C: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ARITH_SHIFT_RIGHT
    && OP.amount >= 8'h20
    |=> RES.carry_wr && RES.carry_out == $past(OP.data[31]))
    else $error("arith shift 32 plus carry not sign");

  AST_ARITH_LAST: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ARITH_SHIFT_RIGHT
    && OP.amount == 8'h1F
    |=> RES.carry_out == $past(OP.data[30]))
    else $error("arith shift carry not bit 30");

  AST_RIGHT_MID: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_LOGIC_SHIFT_RIGHT
    && OP.amount == 8'h04
    |=> RES.result == {4'h0, $past(OP.data[31:4])})
    else $error("logic right by four wrong");

  AST_RIGHT_CARRY: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_LOGIC_SHIFT_RIGHT
    && OP.amount == 8'h05
    |=> RES.carry_wr && RES.carry_out == $past(OP.data[4]))
    else $error("logic right carry not last bit out");

  AST_RIGHT_CLR: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_LOGIC_SHIFT_RIGHT
    && OP.amount >= 8'h21
    |=> RES.carry_wr && !RES.carry_out)
    else $error("logic right 33 plus carry not cleared");

  AST_RIGHT_FULL_C: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_LOGIC_SHIFT_RIGHT
    && OP.amount == 8'h20
    |=> RES.carry_wr && RES.carry_out == $past(OP.data[31]))
    else $error("logic right 32 carry not bit 31");

  AST_LEFT_FULL_C: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_LOGIC_SHIFT_LEFT
    && OP.amount == 8'h20
    |=> RES.carry_wr && RES.carry_out == $past(OP.data[0]))
    else $error("logic left 32 carry not bit 0");

  AST_LEFT_MID: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_LOGIC_SHIFT_LEFT
    && OP.amount == 8'h04
    |=> RES.result == {$past(OP.data[27:0]), 4'h0})
    else $error("logic left by four wrong");

  AST_LEFT_LAST: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_LOGIC_SHIFT_LEFT
    && OP.amount == 8'h1F
    |=> RES.carry_out == $past(OP.data[1]))
    else $error("logic left 31 carry not bit 1");

  AST_LEFT_ZERO_C: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_LOGIC_SHIFT_LEFT
    && OP.amount == 8'h00
    |=> !RES.carry_wr && RES.carry_out == $past(OP.carry_in))
    else $error("logic left zero touched carry");

  AST_ROT_MID: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_ROTATE_RIGHT
    && OP.amount == 8'h08
    |=> RES.result == {$past(OP.data[7:0]), $past(OP.data[31:8])})
    else $error("rotate by eight wrong");

  AST_ROT_CARRY: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ROTATE_RIGHT
    && OP.amount == 8'h08
    |=> RES.carry_wr && RES.carry_out == $past(OP.data[7]))
    else $error("rotate carry not bit n-1");

  AST_ROT_FULL_C: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ROTATE_RIGHT
    && OP.amount == 8'h20
    |=> RES.carry_wr && RES.carry_out == $past(OP.data[31]))
    else $error("rotate by 32 carry not bit 31");

  AST_ROT_WRAP: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.kind == BSC_ROTATE_RIGHT
    && OP.amount == 8'h28
    |=> RES.result == {$past(OP.data[7:0]), $past(OP.data[31:8])})
    else $error("rotate by 40 not as by 8");

  AST_ROT_WRAP_C: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ROTATE_RIGHT
    && OP.amount == 8'h28
    |=> RES.carry_out == $past(OP.data[7]))
    else $error("rotate by 40 carry not bit 7");

  AST_CARRY_WRITE: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd
    && OP.amount != 8'h00
    |=> RES.carry_wr)
    else $error("flag update with nonzero amount not written");

  AST_NO_FLAG: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid
    && !OP.flag_upd
    |=> !RES.carry_wr)
    else $error("carry written without request");

  AST_THRU_WRITE: assert property (@(posedge CLK) disable iff (SRST)
    OP.valid && OP.flag_upd && OP.kind == BSC_ROTATE_THROUGH_CARRY
    && OP.amount == 8'h00
    |=> RES.carry_wr)
    else $error("rotate through carry skipped carry write");

  AST_RESET_CLEAR: assert property (@(posedge CLK)
    SRST
    |=> !RES.valid
    && !RES.carry_wr)
    else $error("reset left an answer standing");

endmodule

/* File: testbench/bsc_flag_model.sv */
// Execute-stage carry flag fed back from the shifter
// Assumes RES is registered and valid for one cycle per request
`timescale 1ns/1ps

module bsc_flag_model
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Shifter answer and flag
  input  wire bsc_pkg::bsc_res_t res,
  output logic                   carry_flag_r
);
  logic carry_flag_nxt;

  always_comb begin
    carry_flag_nxt = carry_flag_r;
    if (res.valid && res.carry_wr) begin
      carry_flag_nxt = res.carry_out;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      carry_flag_r <= 1'b0;
    end else begin
      carry_flag_r <= carry_flag_nxt;
    end
  end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the barrel shifter
// Assumes a one-cycle registered answer and the flag model beside it
`timescale 1ns/1ps

module testbench;
  import bsc_pkg::*;
  logic     CLK;
  logic     SRST;
  logic     carry_r;
  bsc_op_t  op;
  bsc_res_t res;
  int       n_mismatch;
  int       checked;
  int       cycles;

  bsc_shifter bsc_shifter_inst (.CLK(CLK), .SRST(SRST), .OP(op), .RES(res));
  bsc_flag_model bsc_flag_model_inst (.clk(CLK), .srst(SRST), .res(res),
    .carry_flag_r(carry_r));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp32(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(logic got, logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask

  // Expected {carry_wr, carry_out, result}
  function automatic logic [33:0] expect_fn(bsc_kind_t k, int n,
    logic [31:0] d, logic ci, logic f);
    logic [31:0] r;
    logic        c;
    int          m;
    r = d;
    c = ci;
    if (n == 0 && k != BSC_ROTATE_THROUGH_CARRY) begin
      return {1'b0, ci, d};
    end
    case (k)
      BSC_ARITH_SHIFT_RIGHT: begin
        r = (n >= 32) ? {32{d[31]}} : 32'($signed(d) >>> n);
        c = (n >= 32) ? d[31] : d[n-1];
      end
      BSC_LOGIC_SHIFT_RIGHT: begin
        r = (n >= 32) ? 32'h0000_0000 : d >> n;
        c = (n > 32) ? 1'b0 : d[n-1];
      end
      BSC_LOGIC_SHIFT_LEFT: begin
        r = (n >= 32) ? 32'h0000_0000 : d << n;
        c = (n > 32) ? 1'b0 : d[32-n];
      end
      BSC_ROTATE_RIGHT: begin
        m = (n > 32) ? n - 32 : n;
        r = 32'({d, d} >> (m % 32));
        c = d[(m + 31) % 32];
      end
      default: begin
        r = {ci, d[31:1]};
        c = d[0];
      end
    endcase
    return {f, f ? c : ci, r};
  endfunction

  task automatic shot(bsc_kind_t k, int n, logic [31:0] d, logic f,
    bsc_req_t rq);
    logic [33:0] e;
    @(posedge CLK);
    #1;
    op = '{1'b1, rq, k, n[7:0], d, carry_r, f};
    e = expect_fn(k, n, d, carry_r, f);
    @(posedge CLK);
    #1;
    op.valid = 1'b0;
    cmp1(res.valid, 1'b1);
    cmp1(res.req, rq);
    cmp32(res.result, e[31:0]);
    cmp1(res.carry_out, e[32]);
    cmp1(res.carry_wr, e[33]);
  endtask

  // Amount sweep across the 32 and 33 boundaries
  task automatic sweep(bsc_kind_t k, logic [31:0] d);
    int amt[8] = '{1, 5, 31, 32, 33, 40, 63, 64};
    foreach (amt[i]) begin
      shot(k, amt[i], d, 1'b1, BSC_REQ_OPERAND2);
      shot(k, amt[i], ~d, 1'b1, BSC_REQ_STANDALONE);
    end
  endtask

  task automatic t_zero();
    for (int i = 0; i < 4; i++) begin
      shot(bsc_kind_t'(i), 0, 32'hA5A5_0F0F, 1'b1, BSC_REQ_STANDALONE);
    end
  endtask

  task automatic t_thru();
    shot(BSC_LOGIC_SHIFT_LEFT, 1, 32'h8000_0000, 1'b1, BSC_REQ_STANDALONE);
    shot(BSC_ROTATE_THROUGH_CARRY, 0, 32'h0000_0002, 1'b1,
      BSC_REQ_OPERAND2);
    shot(BSC_ROTATE_THROUGH_CARRY, 0, 32'h0000_0003, 1'b1,
      BSC_REQ_STANDALONE);
  endtask

  task automatic t_b2b();
    @(posedge CLK);
    #1;
    op = '{1'b1, BSC_REQ_OPERAND2, BSC_ROTATE_RIGHT, 8'h08, 32'h1234_5678,
      carry_r, 1'b0};
    @(posedge CLK);
    #1;
    op = '{1'b1, BSC_REQ_STANDALONE, BSC_LOGIC_SHIFT_LEFT, 8'h04,
      32'h1234_5678, carry_r, 1'b0};
    cmp32(res.result, 32'h7812_3456);
    cmp1(res.req, BSC_REQ_OPERAND2);
    cmp1(res.carry_wr, 1'b0);
    @(posedge CLK);
    #1;
    op.valid = 1'b0;
    cmp32(res.result, 32'h2345_6780);
    cmp1(res.carry_out, carry_r);
    @(posedge CLK);
    #1;
    cmp1(res.valid, 1'b0);
    cmp1(res.carry_wr, 1'b0);
  endtask

  initial begin
    op = '0;
    SRST = 1'b1;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge CLK);
    #1;
    cmp1(res.valid, 1'b0);
    cmp32(res.result, BSC_RST_RES);
    SRST = 1'b0;
    t_zero();
    sweep(BSC_ARITH_SHIFT_RIGHT, 32'h8000_0011);
    sweep(BSC_LOGIC_SHIFT_RIGHT, 32'h8000_0001);
    sweep(BSC_LOGIC_SHIFT_LEFT, 32'h8000_0001);
    sweep(BSC_ROTATE_RIGHT, 32'h8000_0013);
    t_thru();
    t_b2b();
    tally_and_finish();
  end
endmodule
